// ===== design/cpu_disp_move_multiply_exec.sv
`timescale 1ns/10ps
`include "disp_mul_params.svh"

module cpu_disp_move_multiply_exec (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [31:0] instr_addr_i,
    input wire logic delay_slot_i,
    input wire logic [31:0] branch_target_i,
    input wire logic test_flag_i,
    input wire logic [31:0] src_data_i,
    input wire logic [31:0] dest_data_i,
    input wire logic [31:0] index_reg_zero_i,
    input wire logic next_reads_reg_zero_i,
    input wire logic next_reads_mult_low_i,
    input wire logic [31:0] mem_rdata_i,
    input wire logic mem_ack_i,
    input wire logic [31:0] mult_result_high_i,
    output logic instr_ready_o,
    output logic stall_o,
    output logic [3:0] src_reg_field_o,
    output logic [3:0] dest_reg_field_o,
    output logic mem_req_o,
    output logic mem_write_o,
    output logic [1:0] mem_size_o,
    output logic [31:0] mem_addr_o,
    output logic [31:0] mem_wdata_o,
    output logic reg_we_o,
    output logic [3:0] reg_waddr_o,
    output logic [31:0] reg_wdata_o,
    output logic [31:0] mult_result_low_o,
    output logic [31:0] mult_result_high_o,
    output logic mult_busy_o
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    function automatic logic opc_is(input logic [15:0] ins, input logic [15:0] mask, input logic [15:0] pat);
        opc_is = (ins & mask) == pat;
    endfunction : opc_is

    disp_mul_pkg::exec_state_type state_reg;
    logic [2:0] mul_cnt_reg;
    logic [31:0] mult_low_reg;
    logic [31:0] mul_prod_reg;
    logic ld_sext_reg;
    logic [1:0] ld_size_reg;
    logic [3:0] ld_dest_reg;
    logic dec_st_b, dec_st_w, dec_st_l, dec_ld_b, dec_ld_w, dec_ld_l;
    logic dec_ea, dec_flag, dec_ml, dec_ms, dec_mu, dec_mem, dec_mul;
    logic idle, take;
    logic [31:0] disp_scaled, pc_base, base_reg;
    logic [3:0] disp4;
    logic [31:0] ld_ext;
    logic [31:0] prod_next;

    assign dec_st_b = opc_is(instr_i, `OPC_MASK_HI8, `OPC_ST_BYTE);
    assign dec_st_w = opc_is(instr_i, `OPC_MASK_HI8, `OPC_ST_WORD);
    assign dec_ld_b = opc_is(instr_i, `OPC_MASK_HI8, `OPC_LD_BYTE);
    assign dec_ld_w = opc_is(instr_i, `OPC_MASK_HI8, `OPC_LD_WORD);
    assign dec_st_l = opc_is(instr_i, `OPC_MASK_HI4, `OPC_ST_LONG);
    assign dec_ld_l = opc_is(instr_i, `OPC_MASK_HI4, `OPC_LD_LONG);
    assign dec_ea = opc_is(instr_i, `OPC_MASK_HI8, `OPC_EFF_ADDR);
    assign dec_flag = opc_is(instr_i, `OPC_MASK_FLAG, `OPC_MOVE_FLAG);
    assign dec_ml = opc_is(instr_i, `OPC_MASK_MULW, `OPC_MUL_LONG);
    assign dec_ms = opc_is(instr_i, `OPC_MASK_MULW, `OPC_MUL_SWORD);
    assign dec_mu = opc_is(instr_i, `OPC_MASK_MULW, `OPC_MUL_UWORD);
    assign dec_mem = dec_st_b | dec_st_w | dec_st_l | dec_ld_b | dec_ld_w | dec_ld_l;
    assign dec_mul = dec_ml | dec_ms | dec_mu;
    assign disp4 = instr_i[3:0];

    // Register fields: byte/word forms carry only base in bits 7:4
    always_comb
    begin
        src_reg_field_o = instr_i[7:4];
        dest_reg_field_o = instr_i[11:8];
        if (dec_st_b | dec_st_w)
        begin
            src_reg_field_o = `REG_ZERO;
            dest_reg_field_o = instr_i[7:4];
        end
        else if (dec_ld_b | dec_ld_w)
        begin
            dest_reg_field_o = `REG_ZERO;
        end
    end

    // Displacement scaling per access size
    always_comb
    begin
        disp_scaled = {28'h0000000, disp4};
        base_reg = src_data_i;
        if (dec_st_w | dec_ld_w)
            disp_scaled = {27'h0000000, disp4, 1'b0};
        else if (dec_st_l | dec_ld_l)
            disp_scaled = {26'h0000000, disp4, 2'b00};
        if (dec_st_b | dec_st_w | dec_st_l)
            base_reg = dest_data_i;
    end

    // Program counter base for the effective-address form
    assign pc_base = delay_slot_i ? (branch_target_i + `PC_SLOT_ADD)
                                  : (instr_addr_i + `PC_AHEAD);

    // Sign extension of loaded data
    always_comb
    begin
        ld_ext = mem_rdata_i;
        if (ld_size_reg == `SIZE_BYTE)
            ld_ext = {{24{mem_rdata_i[`BYTE_SIGN_BIT]}}, mem_rdata_i[7:0]};
        else if (ld_size_reg == `SIZE_WORD)
            ld_ext = {{16{mem_rdata_i[`WORD_SIGN_BIT]}}, mem_rdata_i[15:0]};
    end

    // Product selection
    always_comb
    begin
        prod_next = src_data_i * dest_data_i;
        if (dec_ms)
            prod_next = 32'($signed(src_data_i[15:0]) * $signed(dest_data_i[15:0]));
        else if (dec_mu)
            prod_next = {16'h0000, src_data_i[15:0]} * {16'h0000, dest_data_i[15:0]};
    end

    // ------------------------------------------------------------
    // Handshake and stalls
    // ------------------------------------------------------------
    assign idle = state_reg == disp_mul_pkg::ST_IDLE;
    assign take = instr_valid_i & idle;
    assign instr_ready_o = idle;
    // Hold the next reader of register zero or the low result
    assign stall_o = ((state_reg == disp_mul_pkg::ST_MEM) & ld_sext_reg & next_reads_reg_zero_i)
                   | ((state_reg == disp_mul_pkg::ST_MUL) & next_reads_mult_low_i);
    assign mult_busy_o = state_reg == disp_mul_pkg::ST_MUL;
    assign mult_result_low_o = mult_low_reg;
    assign mult_result_high_o = mult_result_high_i;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            state_reg <= disp_mul_pkg::ST_IDLE;
            mul_cnt_reg <= 3'h0;
        end
        else
        begin
            unique case (state_reg)
                disp_mul_pkg::ST_IDLE:
                begin
                    if (take & dec_mem)
                        state_reg <= disp_mul_pkg::ST_MEM;
                    else if (take & dec_mul)
                    begin
                        state_reg <= disp_mul_pkg::ST_MUL;
                        mul_cnt_reg <= dec_ml ? `MUL_LONG_CYCLES : `MUL_WORD_CYCLES;
                    end
                end
                disp_mul_pkg::ST_MEM:
                begin
                    if (mem_ack_i)
                        state_reg <= disp_mul_pkg::ST_IDLE;
                end
                disp_mul_pkg::ST_MUL:
                begin
                    mul_cnt_reg <= mul_cnt_reg - 3'h1;
                    if (mul_cnt_reg == 3'h1)
                        state_reg <= disp_mul_pkg::ST_IDLE;
                end
                default:
                    state_reg <= disp_mul_pkg::ST_IDLE;
            endcase
        end
    end

    // Memory request, held until acknowledged
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mem_req_o <= 1'b0;
            mem_write_o <= 1'b0;
            mem_size_o <= `SIZE_BYTE;
            mem_addr_o <= 32'h00000000;
            mem_wdata_o <= 32'h00000000;
            ld_sext_reg <= 1'b0;
            ld_size_reg <= `SIZE_BYTE;
            ld_dest_reg <= 4'h0;
        end
        else if (take & dec_mem)
        begin
            mem_req_o <= 1'b1;
            mem_write_o <= dec_st_b | dec_st_w | dec_st_l;
            mem_addr_o <= base_reg + disp_scaled;
            ld_sext_reg <= dec_ld_b | dec_ld_w;
            ld_dest_reg <= dest_reg_field_o;
            if (dec_st_b | dec_ld_b)
            begin
                mem_size_o <= `SIZE_BYTE;
                ld_size_reg <= `SIZE_BYTE;
                mem_wdata_o <= {24'h000000, index_reg_zero_i[7:0]};
            end
            else if (dec_st_w | dec_ld_w)
            begin
                mem_size_o <= `SIZE_WORD;
                ld_size_reg <= `SIZE_WORD;
                mem_wdata_o <= {16'h0000, index_reg_zero_i[15:0]};
            end
            else
            begin
                mem_size_o <= `SIZE_LONG;
                ld_size_reg <= `SIZE_LONG;
                mem_wdata_o <= src_data_i;
            end
        end
        else if (mem_req_o & mem_ack_i)
            mem_req_o <= 1'b0;
    end

    // Register write-back
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            reg_we_o <= 1'b0;
            reg_waddr_o <= 4'h0;
            reg_wdata_o <= 32'h00000000;
        end
        else
        begin
            reg_we_o <= 1'b0;
            if (take & dec_ea)
            begin
                reg_we_o <= 1'b1;
                reg_waddr_o <= `REG_ZERO;
                reg_wdata_o <= (pc_base & `PC_ALIGN_MASK) + {22'h000000, instr_i[7:0], 2'b00};
            end
            else if (take & dec_flag)
            begin
                reg_we_o <= 1'b1;
                reg_waddr_o <= instr_i[11:8];
                reg_wdata_o <= {31'h00000000, test_flag_i};
            end
            else if (mem_req_o & mem_ack_i & ~mem_write_o)
            begin
                reg_we_o <= 1'b1;
                reg_waddr_o <= ld_dest_reg;
                reg_wdata_o <= ld_ext;
            end
        end
    end

    // Multiply result low register
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mul_prod_reg <= 32'h00000000;
            mult_low_reg <= 32'h00000000;
        end
        else
        begin
            if (take & dec_mul)
                mul_prod_reg <= prod_next;
            if ((state_reg == disp_mul_pkg::ST_MUL) & (mul_cnt_reg == 3'h1))
                mult_low_reg <= mul_prod_reg;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ea_one_cycle: assert property (@(posedge mclk_i) disable iff (rst_i)
        take & dec_ea |=> reg_we_o & (reg_waddr_o == 4'h0) & instr_ready_o)
        else $error("effective address not written in one cycle");
    chk_flag_value: assert property (@(posedge mclk_i) disable iff (rst_i)
        take & dec_flag |=> reg_we_o & (reg_wdata_o == {31'h0, $past(test_flag_i)}))
        else $error("flag move wrong value");
    chk_mul_long_lat: assert property (@(posedge mclk_i) disable iff (rst_i)
        take & dec_ml |=> mult_busy_o [*2] ##1 !mult_busy_o)
        else $error("long multiply latency wrong");
    chk_mul_word_lat: assert property (@(posedge mclk_i) disable iff (rst_i)
        take & (dec_ms | dec_mu) |=> mult_busy_o ##1 !mult_busy_o)
        else $error("word multiply latency wrong");
    chk_mul_low_value: assert property (@(posedge mclk_i) disable iff (rst_i)
        take & dec_mu |-> ##2 mult_result_low_o ==
            {16'h0, $past(src_data_i[15:0], 2)} * {16'h0, $past(dest_data_i[15:0], 2)})
        else $error("unsigned product wrong");
    chk_high_untouched: assert property (@(posedge mclk_i) disable iff (rst_i)
        mult_busy_o |-> mult_result_high_o == mult_result_high_i)
        else $error("high result altered");
    chk_store_narrow: assert property (@(posedge mclk_i) disable iff (rst_i)
        take & dec_st_b |=> mem_req_o & mem_write_o & (mem_size_o == 2'h0) & (mem_wdata_o[31:8] == 24'h0))
        else $error("byte store not narrowed");
    chk_r0_interlock: assert property (@(posedge mclk_i) disable iff (rst_i)
        mem_req_o & ~mem_write_o & (mem_size_o != 2'h2) & next_reads_reg_zero_i |-> stall_o)
        else $error("register zero read not held");
    chk_word_sext: assert property (@(posedge mclk_i) disable iff (rst_i)
        mem_req_o & mem_ack_i & ~mem_write_o & (ld_size_reg == 2'h1) |=> reg_wdata_o[31:16] == {16{reg_wdata_o[15]}})
        else $error("word load not sign extended");

endmodule : cpu_disp_move_multiply_exec

// ===== design/disp_mul_params.svh
`ifndef DISP_MUL_PARAMS_SVH
`define DISP_MUL_PARAMS_SVH
// Opcode patterns, compared under the matching masks
`define OPC_MASK_HI8 16'hff00
`define OPC_MASK_HI4 16'hf000
`define OPC_MASK_MULW 16'hf00f
`define OPC_MASK_FLAG 16'hf0ff
`define OPC_ST_BYTE 16'h8000
`define OPC_ST_WORD 16'h8100
`define OPC_LD_BYTE 16'h8400
`define OPC_LD_WORD 16'h8500
`define OPC_ST_LONG 16'h1000
`define OPC_LD_LONG 16'h5000
`define OPC_EFF_ADDR 16'hc700
`define OPC_MOVE_FLAG 16'h0029
`define OPC_MUL_LONG 16'h0007
`define OPC_MUL_SWORD 16'h200f
`define OPC_MUL_UWORD 16'h200e
// Program counter handling for the effective-address form
`define PC_AHEAD 32'h00000004
`define PC_SLOT_ADD 32'h00000002
`define PC_ALIGN_MASK 32'hfffffffc
// Sign bits of loaded data
`define BYTE_SIGN_BIT 7
`define WORD_SIGN_BIT 15
// Multiply latencies in cycles, within the documented ranges
`define MUL_LONG_CYCLES 3'h2
`define MUL_WORD_CYCLES 3'h1
// Access sizes on the load/store port
`define SIZE_BYTE 2'h0
`define SIZE_WORD 2'h1
`define SIZE_LONG 2'h2
`define REG_ZERO 4'h0
`endif

// ===== design/disp_mul_pkg.sv
package disp_mul_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MEM = 2'b01,
        ST_MUL = 2'b10
    } exec_state_type;
endpackage : disp_mul_pkg

// ===== verif/data_mem_model.sv
`timescale 1ns/10ps

// ----------------------------------------
// Data memory on the core load/store port
// ----------------------------------------
module data_mem_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic mem_req_i,
    input wire logic [1:0] delay_i,
    input wire logic [31:0] load_val_i,
    output logic mem_ack_o,
    output logic [31:0] mem_rdata_o
);
    logic [1:0] wait_reg;

    // Answers after a chosen wait; read data is scrambled whenever no answer stands
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            wait_reg <= 2'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= 32'h5a5a5a5a;
        end
        else if (mem_req_i && !mem_ack_o && wait_reg == delay_i)
        begin
            wait_reg <= 2'h0;
            mem_ack_o <= 1'b1;
            mem_rdata_o <= load_val_i;
        end
        else
        begin
            wait_reg <= (mem_req_i && !mem_ack_o) ? wait_reg + 2'h1 : 2'h0;
            mem_ack_o <= 1'b0;
            mem_rdata_o <= ~mem_rdata_o;
        end
    end
endmodule : data_mem_model

// ===== verif/tb_cpu_disp_move_multiply_exec.sv
`timescale 1ns/10ps

module tb_cpu_disp_move_multiply_exec;
    logic mclk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, delay_slot_i = 1'b0, test_flag_i = 1'b0;
    logic next_reads_reg_zero_i = 1'b0, next_reads_mult_low_i = 1'b0, mem_ack_i;
    logic [15:0] instr_i = 16'h0000;
    logic [31:0] instr_addr_i = 32'h0, branch_target_i = 32'h0, mult_result_high_i = 32'h0, load_val = 32'h0;
    logic [31:0] src_data_i, dest_data_i, index_reg_zero_i, mem_rdata_i, mem_addr_o, mem_wdata_o;
    logic [31:0] reg_wdata_o, mult_result_low_o, mult_result_high_o;
    logic [3:0] src_reg_field_o, dest_reg_field_o, reg_waddr_o;
    logic [1:0] mem_size_o, delay_val = 2'h0;
    logic instr_ready_o, stall_o, mem_req_o, mem_write_o, reg_we_o, mult_busy_o;
    logic [31:0] regs [16];
    int err_count = 0, checks_done = 0, k = 0;

    // Register file seen through the design's read selects
    assign src_data_i = regs[src_reg_field_o];
    assign dest_data_i = regs[dest_reg_field_o];
    assign index_reg_zero_i = regs[0];

    cpu_disp_move_multiply_exec DUT (.mclk_i(mclk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .instr_addr_i(instr_addr_i), .delay_slot_i(delay_slot_i),
        .branch_target_i(branch_target_i), .test_flag_i(test_flag_i), .src_data_i(src_data_i),
        .dest_data_i(dest_data_i), .index_reg_zero_i(index_reg_zero_i),
        .next_reads_reg_zero_i(next_reads_reg_zero_i), .next_reads_mult_low_i(next_reads_mult_low_i),
        .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i), .mult_result_high_i(mult_result_high_i),
        .instr_ready_o(instr_ready_o), .stall_o(stall_o), .src_reg_field_o(src_reg_field_o),
        .dest_reg_field_o(dest_reg_field_o), .mem_req_o(mem_req_o), .mem_write_o(mem_write_o),
        .mem_size_o(mem_size_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .reg_we_o(reg_we_o),
        .reg_waddr_o(reg_waddr_o), .reg_wdata_o(reg_wdata_o), .mult_result_low_o(mult_result_low_o),
        .mult_result_high_o(mult_result_high_o), .mult_busy_o(mult_busy_o));

    data_mem_model mem (.mclk_i(mclk_i), .rst_i(rst_i), .mem_req_i(mem_req_o), .delay_i(delay_val),
        .load_val_i(load_val), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

    // ----------------------------------------
    // Clock, comparison and closing
    // ----------------------------------------
    initial
    begin
        forever #10 mclk_i = ~mclk_i;
    end

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s: expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Expected values
    // ----------------------------------------
    function automatic logic [31:0] exp_addr(int kind, logic [3:0] n, logic [3:0] m, logic [3:0] d);
        logic [31:0] disp;
        disp = {28'h0, d} << ((kind % 3 == 2) ? 2 : kind % 3);
        return ((kind < 3) ? regs[n] : regs[m]) + disp;
    endfunction : exp_addr

    function automatic logic [31:0] exp_data(int kind, logic [3:0] n, logic [3:0] m, logic [7:0] d8);
        logic [31:0] base;
        base = delay_slot_i ? branch_target_i + 32'h2 : instr_addr_i + 32'h4;
        case (kind)
            0: return {24'h0, regs[0][7:0]};
            1: return {16'h0, regs[0][15:0]};
            2: return regs[m];
            3: return {{24{load_val[7]}}, load_val[7:0]};
            4: return {{16{load_val[15]}}, load_val[15:0]};
            5: return load_val;
            6: return (base & 32'hfffffffc) + {22'h0, d8, 2'h0};
            7: return {31'h0, test_flag_i};
            8: return regs[n] * regs[m];
            9: return $signed(regs[n][15:0]) * $signed(regs[m][15:0]);
            default: return {16'h0, regs[n][15:0]} * {16'h0, regs[m][15:0]};
        endcase
    endfunction : exp_data

    // ----------------------------------------
    // One instruction with its checks
    // ----------------------------------------
    task automatic run_one(input int it);
        int kind;
        int i;
        logic [3:0] n, m, d;
        logic [7:0] d8;
        // Let an edge pass so the valid strobe is never lowered and raised in one step
        @(posedge mclk_i);
        #1;
        for (i = 0; i < 30 && instr_ready_o !== 1'b1; i++)
        begin
            @(posedge mclk_i);
            #1;
        end
        check("ready", 32'h1, {31'h0, instr_ready_o});
        kind = (it < 12) ? it : $urandom_range(11, 0);
        n = $urandom;
        m = $urandom;
        d = (it < 12) ? 4'hf : 4'($urandom);
        d8 = (it < 12) ? 8'hff : 8'($urandom);
        load_val = (it < 12) ? 32'hffff7f80 : $urandom;
        for (i = 0; i < 16; i++)
            regs[i] = $urandom;
        delay_val = $urandom;
        {test_flag_i, delay_slot_i, next_reads_reg_zero_i, next_reads_mult_low_i} = $urandom;
        instr_addr_i = $urandom & 32'hfffffffe;
        branch_target_i = $urandom & 32'hfffffffe;
        mult_result_high_i = $urandom;
        case (kind)
            0: instr_i = {8'h80, n, d};
            1: instr_i = {8'h81, n, d};
            2: instr_i = {4'h1, n, m, d};
            3: instr_i = {8'h84, m, d};
            4: instr_i = {8'h85, m, d};
            5: instr_i = {4'h5, n, m, d};
            6: instr_i = {8'hc7, d8};
            7: instr_i = {4'h0, n, 8'h29};
            8: instr_i = {4'h0, n, m, 4'h7};
            9: instr_i = {4'h2, n, m, 4'hf};
            10: instr_i = {4'h2, n, m, 4'he};
            default: instr_i = 16'h0009;
        endcase
        instr_valid_i = 1'b1;
        @(posedge mclk_i);
        #1;
        instr_valid_i = 1'b0;
        if (kind <= 5)
        begin
            for (i = 0; i < 20 && mem_req_o !== 1'b1; i++)
            begin
                @(posedge mclk_i);
                #1;
            end
            check("request", 32'h1, {31'h0, mem_req_o});
            check("address", exp_addr(kind, n, m, d), mem_addr_o);
            check("size", (kind % 3), {30'h0, mem_size_o});
            check("write", (kind < 3), {31'h0, mem_write_o});
            if (kind < 3)
                check("store data", exp_data(kind, n, m, d8), mem_wdata_o);
            if (kind < 2)
                check("data select", 32'h0, {28'h0, src_reg_field_o});
            if (kind == 3 || kind == 4)
                check("load select", 32'h0, {28'h0, dest_reg_field_o});
            check("load stall", (kind == 3 || kind == 4) && next_reads_reg_zero_i, {31'h0, stall_o});
            for (i = 0; i < 20 && kind >= 3 && reg_we_o !== 1'b1; i++)
            begin
                @(posedge mclk_i);
                #1;
            end
        end
        if ((kind >= 3 && kind <= 5) || kind == 6 || kind == 7)
        begin
            check("write enable", 32'h1, {31'h0, reg_we_o});
            check("write select", (kind == 5 || kind == 7) ? n : 4'h0, {28'h0, reg_waddr_o});
            check("write data", exp_data(kind, n, m, d8), reg_wdata_o);
        end
        if (kind >= 8 && kind <= 10)
        begin
            check("multiply stall", next_reads_mult_low_i, {31'h0, stall_o});
            for (i = 0; i < 10 && mult_busy_o !== 1'b0; i++)
            begin
                @(posedge mclk_i);
                #1;
            end
            check("busy", 32'h0, {31'h0, mult_busy_o});
            check("low result", exp_data(kind, n, m, d8), mult_result_low_o);
            check("high result", mult_result_high_i, mult_result_high_o);
        end
        if (kind == 11)
            check("ignored op", 32'h0, {30'h0, mem_req_o, reg_we_o});
        $display("test %0d kind %0d done", it, kind);
    endtask : run_one

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        for (k = 0; k < 16; k++)
            regs[k] = 32'h0;
        void'($urandom(32'h59c3));
        repeat (20) @(posedge mclk_i);
        #1;
        rst_i = 1'b0;
        for (k = 0; k < 300; k++)
            run_one(k);
        test_done;
    end

    initial
    begin
        #(20 * 20000);
        err_count++;
        test_done;
    end
endmodule : tb_cpu_disp_move_multiply_exec
